// [logic/drs_pkg.sv]
// Notes on behaviour
// RULE1 - controller issues the minimum all-bank refresh count in every rolling 32 ms window
// RULE2 - a full cycle of eight per-bank refreshes counts as one all-bank refresh
// RULE3 - controller issues at most eight all-bank refreshes per rolling burst window
// RULE4 - self refresh time lowers the required count by the rounded-up proportional share
// RULE5 - self refresh entry is CKE, select, CA0, CA1 low and CA2 high at a rising edge
// RULE6 - controller holds CKE high before entry and drives a NOP right after it
// RULE7 - CKE low keeps self refresh; the device ignores every other input meanwhile
// RULE8 - in self refresh the internal timer refreshes, external clock gated, first within residency
// RULE9 - controller stays in self refresh at least the minimum residency time
// RULE10 - controller may change or stop the clock one cycle after entry, restarts it before exit
// RULE11 - exit: stable clock, raise CKE, then wait the exit delay before commands
// RULE12 - during the exit delay CKE stays high and NOPs are driven every edge
// RULE13 - after exit at least one all-bank or eight per-bank refreshes precede re-entry
// RULE14 - controller idles every bank before the self refresh command
// RULE15 - exit delay counts from the first rising edge with CKE high
// RULE16 - controller gives two stable clock cycles before raising CKE on exit
// RULE17 - 8-bit bank mask, one bit per bank; masked bank gets no self refresh
// RULE18 - unmasked bank refreshes only its unmasked segments in self refresh
// RULE19 - eight segment mask bits, each blocking its segment in every bank
// RULE20 - a bank segment refreshes only when both its bank and segment bits are clear
// RULE21 - mask bit 1 means masked, 0 means unmasked
// RULE22 - per-bank refresh leaves other banks usable; the per-bank counter starts at bank 0
// RULE23 - an all-bank refresh resets the per-bank counter to zero
// RULE24 - each per-bank refresh advances the counter, wrapping from the last bank to zero
package drs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_CKESR_NS = 15; // min self refresh residency
  localparam int T_XSR_NS = 140; // self refresh exit delay
  localparam int T_RFCPB_NS = 60; // single bank refresh cycle
  localparam int T_REFI_NS = 3900; // average refresh interval
  localparam int CKESR_CYC = (T_CKESR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int XSR_CYC = (T_XSR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFCPB_CYC = (T_RFCPB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SR_INT_CYC = (T_REFI_NS * 1000) / CLK_PERIOD_PS; // longest time, rounded down
  localparam int CNT_W = 16;

  // ****************************************
  // mode register addresses and command bits
  // ****************************************
  localparam logic [7:0] MA_BANK_MASK = 8'h10; // bank_refresh_mask
  localparam logic [7:0] MA_SEG_MASK = 8'h11; // segment_refresh_mask
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int CA_W = 10;
  localparam int CA_B0 = 0;
  localparam int CA_B1 = 1;
  localparam int CA_B2 = 2;
  localparam int CA_B3 = 3;
  localparam int BANK_W = 3;

  // ****************************************
  // device states
  // ****************************************
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_SREF = 3'h2,
    ST_EXIT = 3'h4
  } drs_state_t;

endpackage

// [logic/drs_refresh_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module drs_refresh_ctrl
  import drs_pkg::*;
#(
  parameter int N_BANKS = 8,
  parameter int N_SEGS = 8,
  parameter int SR_INTERVAL = SR_INT_CYC
)
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  // command pins, rising and falling halves of the command word
  input wire logic I_CKE,
  input wire logic I_CS_N,
  input wire logic [CA_W-1:0] I_CA_RISE,
  input wire logic [CA_W-1:0] I_CA_FALL,
  // status toward the array
  output logic O_SELF_REFRESH,
  output logic O_CLK_GATED,
  output logic O_EXIT_WAIT,
  output logic O_INT_REFRESH,
  output logic [N_BANKS*N_SEGS-1:0] O_REFRESH_MAP,
  output logic [BANK_W-1:0] O_PB_BANK,
  output logic [N_BANKS-1:0] O_PB_BUSY,
  output logic O_REF_EQUIV,
  output logic [7:0] O_BANK_MASK,
  output logic [7:0] O_SEG_MASK
);

  // ****************************************
  // registers
  // ****************************************
  drs_state_t state_ff, nxt_state;
  logic cke_ff;
  logic [CNT_W-1:0] xsr_cnt_ff, nxt_xsr_cnt;
  logic [CNT_W-1:0] sr_tmr_ff, nxt_sr_tmr;
  logic [CNT_W-1:0] pb_cnt_ff;
  logic [BANK_W-1:0] pb_ptr_ff;
  logic [7:0] bank_mask_ff, seg_mask_ff;
  logic int_ref_ff, ref_equiv_ff, exit_wait_ff, sref_ff;
  logic [N_BANKS*N_SEGS-1:0] map_ff;

  // ****************************************
  // command decode
  // ****************************************
  wire sel = !I_CS_N;
  wire ca0 = I_CA_RISE[CA_B0];
  wire ca1 = I_CA_RISE[CA_B1];
  wire ca2 = I_CA_RISE[CA_B2];
  wire ca3 = I_CA_RISE[CA_B3];
  // commands count only once the exit delay is over
  wire cmd_ok = (state_ff == ST_IDLE) || ((state_ff == ST_EXIT) && (xsr_cnt_ff == '0));
  wire ref_cmd = cmd_ok && cke_ff && I_CKE && sel && !ca0 && !ca1 && ca2;
  wire all_bank_refresh_cmd = ref_cmd && ca3;
  wire per_bank_refresh_cmd = ref_cmd && !ca3;
  wire sre_cmd = cmd_ok && cke_ff && !I_CKE && sel && !ca0 && !ca1 && ca2; // [RULE5]
  wire mrw_cmd = cmd_ok && cke_ff && I_CKE && sel && !ca0 && !ca1 && !ca2 && !ca3;
  // mode register address: rising CA9..CA4 over falling CA1..CA0
  wire [7:0] mrw_addr = {I_CA_RISE[9:4], I_CA_FALL[1:0]};
  wire [7:0] mrw_data = I_CA_FALL[9:2];
  wire wr_bank_mask = mrw_cmd && (mrw_addr == MA_BANK_MASK);
  wire wr_seg_mask = mrw_cmd && (mrw_addr == MA_SEG_MASK);
  wire pb_last = (pb_ptr_ff == BANK_W'(N_BANKS - 1));

  // ****************************************
  // refresh enable map: bit b*N_SEGS+s
  // ****************************************
  logic [N_BANKS*N_SEGS-1:0] refresh_map;
  genvar gb, gs;
  generate
    for (gb = 0; gb < N_BANKS; gb++)
    begin : g_bank
      for (gs = 0; gs < N_SEGS; gs++)
      begin : g_seg
        // a set bit masks; both must be clear to refresh
        assign refresh_map[gb*N_SEGS+gs] = !bank_mask_ff[gb] && !seg_mask_ff[gs]; // [RULE17] [RULE18] [RULE19] [RULE20] [RULE21]
      end
    end
  endgenerate

  // ****************************************
  // state sequencing
  // ****************************************
  // no new internal refresh once the exit delay has run out, so a strobe never
  // meets a mask write on the edge at which the device leaves self refresh
  wire sr_due = (state_ff == ST_SREF) || ((state_ff == ST_EXIT) && (xsr_cnt_ff != '0));
  wire sr_fire = sr_due && (sr_tmr_ff == '0);

  // next state; in self refresh only CKE is looked at
  always_comb
  begin
    nxt_state = state_ff;
    nxt_xsr_cnt = xsr_cnt_ff;
    nxt_sr_tmr = sr_tmr_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (sre_cmd)
        begin
          nxt_state = ST_SREF;
          nxt_sr_tmr = '0; // first internal refresh on the next edge, well inside residency [RULE8]
        end
      end
      ST_SREF:
      begin
        nxt_sr_tmr = sr_fire ? CNT_W'(SR_INTERVAL - 1) : sr_tmr_ff - 1'b1;
        if (I_CKE) // [RULE7]
        begin
          nxt_state = ST_EXIT;
          nxt_xsr_cnt = CNT_W'(XSR_CYC - 1); // first edge with CKE high is cycle 0 [RULE15]
        end
      end
      ST_EXIT:
      begin
        // internal refresh keeps running so one in progress can finish
        nxt_sr_tmr = sr_fire ? CNT_W'(SR_INTERVAL - 1) : sr_tmr_ff - 1'b1;
        if (!I_CKE && xsr_cnt_ff != '0)
        begin
          nxt_state = ST_SREF; // re-entry during the exit delay
        end
        else if (xsr_cnt_ff != '0)
        begin
          nxt_xsr_cnt = xsr_cnt_ff - 1'b1;
        end
        else if (sre_cmd)
        begin
          nxt_state = ST_SREF;
          nxt_sr_tmr = '0;
        end
        else
        begin
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state, counters and CKE history
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_ff <= ST_IDLE;
      cke_ff <= 1'b0;
      xsr_cnt_ff <= '0;
      sr_tmr_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cke_ff <= I_CKE;
      xsr_cnt_ff <= nxt_xsr_cnt;
      sr_tmr_ff <= nxt_sr_tmr;
    end
  end

  // ****************************************
  // mask registers, written by mode register write
  // ****************************************
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      bank_mask_ff <= MASK_RESET;
      seg_mask_ff <= MASK_RESET;
    end
    else
    begin
      if (wr_bank_mask)
      begin
        bank_mask_ff <= mrw_data; // [RULE17]
      end
      if (wr_seg_mask)
      begin
        seg_mask_ff <= mrw_data; // [RULE19]
      end
    end
  end

  // ****************************************
  // per-bank refresh pointer and busy window
  // ****************************************
  // only the addressed bank is busy; the rest stay usable
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      pb_ptr_ff <= '0; // [RULE22]
      pb_cnt_ff <= '0;
      ref_equiv_ff <= 1'b0;
    end
    else
    begin
      ref_equiv_ff <= all_bank_refresh_cmd || (per_bank_refresh_cmd && pb_last); // [RULE2]
      if (all_bank_refresh_cmd)
      begin
        pb_ptr_ff <= '0; // [RULE23]
      end
      else if (per_bank_refresh_cmd)
      begin
        pb_ptr_ff <= pb_last ? '0 : pb_ptr_ff + 1'b1; // [RULE24]
        pb_cnt_ff <= CNT_W'(RFCPB_CYC);
      end
      else if (pb_cnt_ff != '0)
      begin
        pb_cnt_ff <= pb_cnt_ff - 1'b1;
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // the map is frozen into the strobe so the array sees a stable set
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      int_ref_ff <= 1'b0;
      map_ff <= '0;
      exit_wait_ff <= 1'b0;
      sref_ff <= 1'b0;
    end
    else
    begin
      int_ref_ff <= sr_fire; // [RULE8]
      map_ff <= sr_fire ? refresh_map : '0; // [RULE18] [RULE20]
      exit_wait_ff <= (nxt_state == ST_EXIT) && (nxt_xsr_cnt != '0); // [RULE15]
      sref_ff <= (nxt_state != ST_IDLE); // [RULE8]
    end
  end

  // busy flags kept in a flop so the pins never glitch while the counter decodes
  logic [N_BANKS-1:0] pb_sel;
  logic [N_BANKS-1:0] pb_busy_ff;
  generate
    for (gb = 0; gb < N_BANKS; gb++)
    begin : g_busy
      assign pb_sel[gb] = (pb_ptr_ff == BANK_W'(gb));
    end
  endgenerate
  // busy ends with the last count; an all-bank refresh freezes the count
  wire pb_done = !all_bank_refresh_cmd && (pb_cnt_ff == CNT_W'(1));

  // only the addressed bank is flagged busy
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      pb_busy_ff <= '0;
    end
    else if (per_bank_refresh_cmd)
    begin
      pb_busy_ff <= pb_sel; // [RULE22]
    end
    else if (pb_done)
    begin
      pb_busy_ff <= '0;
    end
  end

  assign O_SELF_REFRESH = sref_ff;
  assign O_CLK_GATED = sref_ff; // external clock ignored internally [RULE8]
  assign O_EXIT_WAIT = exit_wait_ff;
  assign O_INT_REFRESH = int_ref_ff;
  assign O_REFRESH_MAP = map_ff;
  assign O_PB_BANK = pb_ptr_ff;
  assign O_PB_BUSY = pb_busy_ff;
  assign O_REF_EQUIV = ref_equiv_ff;
  assign O_BANK_MASK = bank_mask_ff;
  assign O_SEG_MASK = seg_mask_ff;

endmodule
`default_nettype wire

// [verif/drs_refresh_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module drs_refresh_chk
  import drs_pkg::*;
#(
  parameter int N_BANKS = 8,
  parameter int N_SEGS = 8,
  parameter int SR_INTERVAL = SR_INT_CYC
)
(
  // clock, reset and command pins
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic I_CKE,
  input wire logic I_CS_N,
  input wire logic [CA_W-1:0] I_CA_RISE,
  input wire logic [CA_W-1:0] I_CA_FALL,
  // status of the design
  input wire logic O_SELF_REFRESH,
  input wire logic O_CLK_GATED,
  input wire logic O_EXIT_WAIT,
  input wire logic O_INT_REFRESH,
  input wire logic [N_BANKS*N_SEGS-1:0] O_REFRESH_MAP,
  input wire logic [BANK_W-1:0] O_PB_BANK,
  input wire logic [N_BANKS-1:0] O_PB_BUSY,
  input wire logic O_REF_EQUIV,
  input wire logic [7:0] O_BANK_MASK,
  input wire logic [7:0] O_SEG_MASK
);
  // ****************************************
  // command decode
  // ****************************************
  logic cke_q_ff;
  logic [7:0] fall_q_ff;
  logic [N_BANKS*N_SEGS-1:0] exp_map;
  // previous-edge cke gates every command, so it is kept here
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    if (I_SYS_RST)
    begin
      cke_q_ff <= 1'b0;
      fall_q_ff <= 8'h00;
    end
    else
    begin
      cke_q_ff <= I_CKE;
      fall_q_ff <= I_CA_FALL[9:2];
    end
  // exit-delay commands left out on purpose, the idle case is enough
  wire logic take = cke_q_ff & I_CKE & ~I_CS_N & ~O_SELF_REFRESH;
  wire logic t_all_bank_refresh = take & (I_CA_RISE[3:0] == 4'hc);
  wire logic t_per_bank_refresh = take & (I_CA_RISE[3:0] == 4'h4);
  wire logic t_mrwb = take & (I_CA_RISE == 10'h040) & (I_CA_FALL[1:0] == 2'b00);
  wire logic t_sre = cke_q_ff & ~I_CKE & ~I_CS_N & ~O_SELF_REFRESH & (I_CA_RISE[2:0] == 3'b100);
  // a segment is refreshed only when both mask bits are clear
  always_comb
  begin
    for (int b = 0; b < N_BANKS; b++)
      for (int s = 0; s < N_SEGS; s++)
        exp_map[b*N_SEGS+s] = ~(O_BANK_MASK[b] | O_SEG_MASK[s]);
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  property p_sre; t_sre |=> O_SELF_REFRESH && O_CLK_GATED; endproperty
  a_sre: assert property (p_sre) else $error("entry not taken");
  property p_first; $rose(O_SELF_REFRESH) |=> O_INT_REFRESH; endproperty
  a_first: assert property (p_first) else $error("no early internal refresh");
  property p_map; O_INT_REFRESH |-> O_SELF_REFRESH && O_REFRESH_MAP == exp_map; endproperty
  a_map: assert property (p_map) else $error("refresh map wrong");
  property p_hold; O_SELF_REFRESH && !I_CKE |=> $stable(O_BANK_MASK) && $stable(O_PB_BANK); endproperty
  a_hold: assert property (p_hold) else $error("input acted on in self refresh");
  property p_exit; $rose(O_EXIT_WAIT) |-> $past(I_CKE) && !$past(I_CKE, 2); endproperty
  a_exit: assert property (p_exit) else $error("exit delay start wrong");
  property p_all_bank_refresh; t_all_bank_refresh |=> O_REF_EQUIV && O_PB_BANK == '0; endproperty
  a_all_bank_refresh: assert property (p_all_bank_refresh) else $error("all-bank refresh effect wrong");
  property p_pb;
    t_per_bank_refresh |=> O_PB_BANK == $past(O_PB_BANK) + 3'h1 && O_PB_BUSY == N_BANKS'(1) << $past(O_PB_BANK)
      && O_REF_EQUIV == ($past(O_PB_BANK) == 3'h7);
  endproperty
  a_pb: assert property (p_pb) else $error("per-bank refresh effect wrong");
  property p_mrw; t_mrwb |=> O_BANK_MASK == fall_q_ff; endproperty
  a_mrw: assert property (p_mrw) else $error("bank mask write lost");
  c_sre: cover property (t_sre);
  c_wrap: cover property (t_per_bank_refresh && O_PB_BANK == 3'h7);
  c_exit: cover property ($rose(O_EXIT_WAIT));
endmodule
bind drs_refresh_ctrl drs_refresh_chk #(.N_BANKS(N_BANKS), .N_SEGS(N_SEGS), .SR_INTERVAL(SR_INTERVAL)) u_chk (
  .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_CKE(I_CKE), .I_CS_N(I_CS_N), .I_CA_RISE(I_CA_RISE),
  .I_CA_FALL(I_CA_FALL), .O_SELF_REFRESH(O_SELF_REFRESH), .O_CLK_GATED(O_CLK_GATED), .O_EXIT_WAIT(O_EXIT_WAIT),
  .O_INT_REFRESH(O_INT_REFRESH), .O_REFRESH_MAP(O_REFRESH_MAP), .O_PB_BANK(O_PB_BANK), .O_PB_BUSY(O_PB_BUSY),
  .O_REF_EQUIV(O_REF_EQUIV), .O_BANK_MASK(O_BANK_MASK), .O_SEG_MASK(O_SEG_MASK));
`default_nettype wire

// [verif/drs_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
module drs_ctrl_model
  import drs_pkg::*;
(
  // clock from the bench
  input wire logic i_mclk,
  // command pins toward the device
  output logic o_cke,
  output logic o_cs_n,
  output logic [CA_W-1:0] o_ca_rise,
  output logic [CA_W-1:0] o_ca_fall
);
  // ****************************************
  // command driver
  // ****************************************
  localparam logic [CA_W-1:0] CA_NOP = 10'h007;
  // run is far shorter than a window, few all-bank refreshes
  initial
  begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    o_ca_rise = CA_NOP;
    o_ca_fall = '0;
  end
  // banks always idle here; cke high before entry and held low after it
  task automatic cmd(input logic c, input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
    @(negedge i_mclk);
    o_cke = c;
    o_cs_n = 1'b0;
    o_ca_rise = r;
    o_ca_fall = f;
    @(negedge i_mclk);
    o_ca_rise = CA_NOP; // nop in the cycle after
    o_ca_fall = ~f; // released half shows no stale value
  endtask
  // clock never stops, so two stable cycles then cke high
  task automatic leave_sr();
    repeat (2) @(negedge i_mclk);
    o_cke = 1'b1;
  endtask
endmodule
`default_nettype wire

// [verif/dram_refresh_self_refresh_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module dram_refresh_self_refresh_tb_top
  import drs_pkg::*;
;
  localparam logic [CA_W-1:0] CA_ALL_BANK_REFRESH = 10'h00c;
  localparam logic [CA_W-1:0] CA_PER_BANK_REFRESH = 10'h004;
  localparam logic [CA_W-1:0] CA_MRW = 10'h040;
  logic mclk, sys_rst, cke, cs_n, sref, gated, xwait, iref, equiv;
  logic [CA_W-1:0] ca_r, ca_f;
  logic [63:0] rmap, emap;
  logic [BANK_W-1:0] pb_bank;
  logic [7:0] pb_busy, bmask, smask;
  int miscompares = 0;
  int n_checks = 0;
  // ****************************************
  // checking and verdict
  // ****************************************
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // run needs a few hundred cycles, 4000 means a hang
  initial
  begin
    #20000;
    miscompares++;
    give_verdict();
  end
  drs_ctrl_model i_ctl (.i_mclk(mclk), .o_cke(cke), .o_cs_n(cs_n), .o_ca_rise(ca_r), .o_ca_fall(ca_f));
  // short internal interval puts several strobes into the brief self refresh phase
  drs_refresh_ctrl #(.SR_INTERVAL(4)) i_dut (.I_MCLK(mclk), .I_SYS_RST(sys_rst), .I_CKE(cke), .I_CS_N(cs_n),
    .I_CA_RISE(ca_r), .I_CA_FALL(ca_f), .O_SELF_REFRESH(sref), .O_CLK_GATED(gated), .O_EXIT_WAIT(xwait),
    .O_INT_REFRESH(iref), .O_REFRESH_MAP(rmap), .O_PB_BANK(pb_bank), .O_PB_BUSY(pb_busy),
    .O_REF_EQUIV(equiv), .O_BANK_MASK(bmask), .O_SEG_MASK(smask));
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk("bank_mask", 8'h00, bmask);
    chk("pb_bank", 0, pb_bank);
    // eleven per-bank refreshes cross the wrap once
    for (int b = 0; b < 11; b++)
    begin
      i_ctl.cmd(1'b1, CA_PER_BANK_REFRESH, '0);
      chk("pb_busy", 64'h1 << (b % 8), pb_busy);
      chk("pb_bank", (b + 1) % 8, pb_bank);
      chk("ref_equiv", b == 7, equiv);
      repeat (RFCPB_CYC) @(negedge mclk);
      chk("pb_busy", 0, pb_busy);
    end
    i_ctl.cmd(1'b1, CA_ALL_BANK_REFRESH, '0);
    chk("ref_equiv", 1, equiv);
    chk("pb_bank", 0, pb_bank);
    repeat (40) @(negedge mclk);
    i_ctl.cmd(1'b1, CA_MRW, {8'h82, 2'b00});
    i_ctl.cmd(1'b1, CA_MRW, {8'h84, 2'b01});
    i_ctl.cmd(1'b1, 10'h080, {8'hff, 2'b00}); // unmapped address
    chk("bank_mask", 8'h82, bmask);
    chk("seg_mask", 8'h84, smask);
    for (int b = 0; b < 8; b++)
      for (int s = 0; s < 8; s++)
        emap[b*8+s] = !(b == 1 || b == 7 || s == 2 || s == 7);
    i_ctl.cmd(1'b0, CA_PER_BANK_REFRESH, '0);
    chk("self_refresh", 1, sref);
    chk("clk_gated", 1, gated);
    @(negedge mclk);
    chk("int_refresh", 1, iref);
    chk("refresh_map", emap, rmap);
    i_ctl.cmd(1'b0, CA_MRW, {8'hff, 2'b00}); // pins are don't care now
    chk("bank_mask", 8'h82, bmask);
    i_ctl.leave_sr();
    @(negedge mclk);
    chk("exit_wait", 1, xwait);
    repeat (XSR_CYC - 3) @(negedge mclk);
    chk("exit_wait", 1, xwait);
    repeat (2) @(negedge mclk);
    chk("exit_wait", 0, xwait);
    i_ctl.cmd(1'b1, CA_ALL_BANK_REFRESH, '0);
    chk("ref_equiv", 1, equiv);
    chk("self_refresh", 0, sref);
    chk("clk_gated", 0, gated);
    give_verdict();
  end
endmodule
`default_nettype wire
